//--- rtl/tdbg_pkg.sv
package tdbg_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int FIFO_W = ADDR_W + DATA_W;
   localparam int FIFO_DEPTH = 16;
   localparam logic [3:0] SEP_BIT = 4'h8;
   localparam logic [3:0] RW_BIT = 4'h7;
   localparam logic [6:0] WR_TOP = 7'h30;
   localparam logic [6:0] RD_TOP = 7'h20;
   localparam logic [6:0] BUS_REG_ADDR = 7'h17;
   localparam int GRANT_EN_BIT = 7;
   localparam int GRANT_STAT_BIT = 0;
   localparam logic RW_READ = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD = 2'b01,
      ST_DATA = 2'b10
   } tdbg_state_t;
endpackage : tdbg_pkg

//--- rtl/tdbg_fifo.sv
`timescale 1ns/1ps
module tdbg_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16
) (
   input wire logic core_clk, // system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic in_valid, // push request
   output logic in_ready, // space available
   input wire logic [WIDTH-1:0] in_data, // pushed word
   output logic out_valid, // word available
   input wire logic out_ready, // consumer takes word
   output logic [WIDTH-1:0] out_data // oldest word
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0] wr_ptr_reg;
   logic [PW:0] rd_ptr_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire ptr_same = wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0];

   assign in_ready = !(ptr_same && (wr_ptr_reg[PW] != rd_ptr_reg[PW]));
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign out_data = mem[rd_ptr_reg[PW-1:0]];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_reg[PW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + (PW+1)'(push);
         rd_ptr_reg <= rd_ptr_reg + (PW+1)'(pop);
      end
   end
endmodule : tdbg_fifo

//--- rtl/tdbg_slave.sv
`timescale 1ns/1ps
module tdbg_slave (
   input wire logic core_clk, // system clock, 200 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic debug_serial_clock, // serial clock from master
   input wire logic debug_serial_data_in, // data line level
   output logic debug_serial_data_out, // data line drive value
   output logic debug_serial_data_oe, // high while we drive data
   output logic instr_power_down, // port selected, instrumentation off
   output logic [6:0] rd_addr, // read space address
   output logic rd_strobe, // one-cycle read access pulse
   input wire logic [7:0] rd_data, // read space data, same clock
   output logic wr_valid, // write access pending
   input wire logic wr_ready, // register file takes write
   output logic [6:0] wr_addr, // write space address
   output logic [7:0] wr_data, // write data
   output logic wr_space, // write buffer can accept a byte
   input wire logic break_req, // debug break request
   output logic core_halt, // halts the processor core only
   input wire logic external_bus_request, // bus request pin
   output logic bus_grant // bus grant pin
);
   // pin synchronisers; first stage feeds only the second
   logic scl_s1_reg, scl_s2_reg, scl_prev_reg;
   logic sda_s1_reg, sda_s2_reg, sda_prev_reg;
   logic req_s1_reg, req_s2_reg;
   logic mode_reg;
   tdbg_pkg::tdbg_state_t state_reg, state_next;
   logic [3:0] bit_cnt_reg;
   logic [7:0] sh_reg;
   logic [6:0] addr_reg;
   logic rw_reg;
   logic load_pend_reg;
   logic sda_out_reg, sda_oe_reg;
   logic grant_en_reg, sep_high_reg, bus_grant_reg;
   logic core_halt_reg;
   logic rd_strobe_reg;

   function automatic logic is_bus_reg(input logic [6:0] a);
      return a == tdbg_pkg::BUS_REG_ADDR;
   endfunction : is_bus_reg

   always_ff @(posedge core_clk) begin
      scl_s1_reg <= debug_serial_clock;
      scl_s2_reg <= scl_s1_reg;
      scl_prev_reg <= scl_s2_reg;
      sda_s1_reg <= debug_serial_data_in;
      sda_s2_reg <= sda_s1_reg;
      sda_prev_reg <= sda_s2_reg;
      req_s1_reg <= external_bus_request;
      req_s2_reg <= req_s1_reg;
   end

   // edges come from synced samples only, never from the first stage
   wire scl_rise = scl_s2_reg && !scl_prev_reg;
   wire scl_fall = !scl_s2_reg && scl_prev_reg;
   wire scl_high = scl_s2_reg && scl_prev_reg;
   // only a fall with the clock high opens a frame; a rise is not decoded
   wire start_det = mode_reg && scl_high && sda_prev_reg
                    && !sda_s2_reg;
   wire sep_edge = scl_rise && (bit_cnt_reg == tdbg_pkg::SEP_BIT);
   wire data_edge = scl_rise && (bit_cnt_reg < tdbg_pkg::SEP_BIT);
   wire shift_in = data_edge && (state_reg == tdbg_pkg::ST_CMD || !rw_reg);
   wire cmd_done = (state_reg == tdbg_pkg::ST_CMD) && sep_edge;
   wire in_data = state_reg == tdbg_pkg::ST_DATA;
   wire wr_byte = in_data && !rw_reg && sep_edge;
   wire rd_byte = in_data && rw_reg && sep_edge;
   wire rd_go = (cmd_done && sh_reg[0] == tdbg_pkg::RW_READ) || rd_byte;
   wire [6:0] wr_addr_inc = (addr_reg == tdbg_pkg::WR_TOP) ? addr_reg
                            : addr_reg + 7'h01;
   wire [6:0] rd_addr_inc = (addr_reg == tdbg_pkg::RD_TOP) ? addr_reg
                            : addr_reg + 7'h01;
   wire [6:0] cmd_addr = sh_reg[7:1];
   wire [6:0] rd_addr_next = cmd_done ? cmd_addr : rd_addr_inc;
   // bus status answers from our own space; everything else is outside
   wire [7:0] status_byte = 8'(bus_grant_reg) << tdbg_pkg::GRANT_STAT_BIT;
   wire [7:0] rd_sel = is_bus_reg(rd_addr) ? status_byte : rd_data;
   wire [2:0] out_idx = 3'h7 - bit_cnt_reg[2:0];
   wire fifo_in_ready;
   wire fifo_push = wr_byte && !is_bus_reg(addr_reg);
   wire [14:0] fifo_out;

   // strap sampled while reset is held, so the last value before release wins
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mode_reg <= scl_s2_reg;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         tdbg_pkg::ST_IDLE: state_next = tdbg_pkg::ST_IDLE;
         tdbg_pkg::ST_CMD: begin
            if (cmd_done) begin
               state_next = tdbg_pkg::ST_DATA;
            end
         end
         tdbg_pkg::ST_DATA: state_next = tdbg_pkg::ST_DATA;
         default: state_next = tdbg_pkg::ST_IDLE;
      endcase
      if (start_det) begin
         state_next = tdbg_pkg::ST_CMD;
      end
      if (!mode_reg) begin
         state_next = tdbg_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= tdbg_pkg::ST_IDLE;
         bit_cnt_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (start_det) begin
            bit_cnt_reg <= 4'h0;
         end else if (state_reg != tdbg_pkg::ST_IDLE && scl_rise) begin
            bit_cnt_reg <= sep_edge ? 4'h0 : bit_cnt_reg + 4'h1;
         end
      end
   end

   // bits taken on the clock's rising edge, msb arrives first
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sh_reg <= 8'h00;
      end else if (load_pend_reg) begin
         sh_reg <= rd_sel;
      end else if (shift_in) begin
         sh_reg <= {sh_reg[6:0], sda_s2_reg};
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         addr_reg <= 7'h00;
         rw_reg <= 1'b0;
         rd_addr <= 7'h00;
         rd_strobe_reg <= 1'b0;
         load_pend_reg <= 1'b0;
      end else begin
         rd_strobe_reg <= rd_go;
         load_pend_reg <= rd_strobe_reg;
         if (cmd_done) begin
            addr_reg <= cmd_addr;
            rw_reg <= sh_reg[0];
         end else if (wr_byte) begin
            addr_reg <= wr_addr_inc;
         end else if (rd_byte) begin
            addr_reg <= rd_addr_inc;
         end
         if (rd_go) begin
            rd_addr <= rd_addr_next;
         end
      end
   end

   // read bits change on the falling edge so they are stable at the rise
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sda_out_reg <= 1'b1;
         sda_oe_reg <= 1'b0;
      end else if (start_det || !in_data || !rw_reg) begin
         sda_oe_reg <= 1'b0;
      end else if (scl_fall) begin
         sda_oe_reg <= bit_cnt_reg < tdbg_pkg::SEP_BIT;
         sda_out_reg <= sh_reg[out_idx];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         grant_en_reg <= 1'b0;
         sep_high_reg <= 1'b0;
         bus_grant_reg <= 1'b0;
         core_halt_reg <= 1'b0;
      end else begin
         core_halt_reg <= break_req;
         if (wr_byte && is_bus_reg(addr_reg)) begin
            grant_en_reg <= sh_reg[tdbg_pkg::GRANT_EN_BIT];
         end
         if (start_det || data_edge) begin
            sep_high_reg <= 1'b0;
         end else if (sep_edge && state_reg != tdbg_pkg::ST_IDLE) begin
            sep_high_reg <= sda_s2_reg;
         end
         bus_grant_reg <= grant_en_reg && req_s2_reg
                          && (state_reg == tdbg_pkg::ST_IDLE
                              || sep_high_reg);
      end
   end

   tdbg_fifo #(
      .WIDTH(tdbg_pkg::FIFO_W),
      .DEPTH(tdbg_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data({addr_reg, sh_reg}),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(fifo_out)
   );

   assign wr_addr = fifo_out[14:8];
   assign wr_data = fifo_out[7:0];
   assign wr_space = fifo_in_ready;
   assign debug_serial_data_out = sda_out_reg;
   assign debug_serial_data_oe = sda_oe_reg;
   assign instr_power_down = mode_reg;
   assign rd_strobe = rd_strobe_reg;
   assign bus_grant = bus_grant_reg;
   assign core_halt = core_halt_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   chk_idle_ignore: assert property (
      state_reg == tdbg_pkg::ST_IDLE && !start_det
      |=> state_reg == tdbg_pkg::ST_IDLE)
      else $error("traffic accepted without start");
   chk_start_cmd: assert property (
      start_det |=> state_reg == tdbg_pkg::ST_CMD && bit_cnt_reg == 4'h0)
      else $error("start did not open a command");
   chk_rise_none: assert property (
      scl_high && !sda_prev_reg && sda_s2_reg && !scl_rise
      |=> $stable(state_reg) && $stable(bit_cnt_reg))
      else $error("data rise with clock high changed state");
   chk_frame_nine: assert property (
      state_reg != tdbg_pkg::ST_IDLE && !start_det && sep_edge
      |=> bit_cnt_reg == 4'h0)
      else $error("frame not nine clocks");
   chk_wr_sat: assert property (
      wr_byte && addr_reg == tdbg_pkg::WR_TOP && !start_det
      |=> addr_reg == tdbg_pkg::WR_TOP)
      else $error("write address passed top");
   chk_rd_sat: assert property (
      rd_byte && addr_reg == tdbg_pkg::RD_TOP && !start_det
      |=> addr_reg == tdbg_pkg::RD_TOP)
      else $error("read address passed top");
   chk_rd_load: assert property (
      rd_go |=> ##2 sh_reg == $past(rd_sel))
      else $error("shifter not loaded after separator");
   chk_msb_first: assert property (
      scl_fall && in_data && rw_reg && bit_cnt_reg == 4'h0 && !start_det
      |=> sda_out_reg == $past(sh_reg[7]) && sda_oe_reg)
      else $error("read byte not msb first");
   chk_oe_fall: assert property (
      $rose(sda_oe_reg) |-> $past(scl_fall))
      else $error("data drive began off a falling edge");
   chk_grant_off: assert property (
      !grant_en_reg |=> !bus_grant_reg)
      else $error("grant without enable");
   chk_grant_idle: assert property (
      grant_en_reg && req_s2_reg
      && (state_reg == tdbg_pkg::ST_IDLE || sep_high_reg)
      |=> bus_grant_reg)
      else $error("idle request not granted");
endmodule : tdbg_slave

//--- verif/tdbg_master.sv
`timescale 1ns/1ps
module tdbg_master (
   output logic scl, // serial clock to the slave
   output logic m_out, // data value driven
   output logic m_oe, // high while the master drives data
   input wire logic sda // resolved data line
);
   // a 48 ns bit period keeps the clock under half the core rate
   initial begin
      scl = 1'b1;
      m_out = 1'b1;
      m_oe = 1'b0;
   end
   // data goes high with clock low, then falls with clock high
   task automatic start();
      scl = 1'b0;
      #6;
      m_oe = 1'b1;
      m_out = 1'b1;
      #18;
      scl = 1'b1;
      #24;
      m_out = 1'b0;
      #24;
   endtask : start
   // clock is left high after each bit, so it stands high between frames
   task automatic bit_io(input logic d, input logic drv, input logic gl,
         output logic q);
      scl = 1'b0;
      // data waits over a core cycle after the fall, so no false start
      #6;
      m_oe = drv;
      m_out = d; // data bit is set while clock is low; only the gl rise comes with clock high
      #18;
      scl = 1'b1;
      #12;
      if (gl) begin
         m_out = 1'b1; // a rise with clock high that the slave must ignore
      end
      #12;
      q = sda;
   endtask : bit_io
   task automatic xfer(input logic [7:0] d, input logic rd, input logic sep,
         input logic gl, output logic [7:0] q);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], !rd, gl && i == 7, s); // msb first, whole bytes
         q[i] = s;
      end
      bit_io(sep, 1'b1, 1'b0, s); // ninth clock carries separator
   endtask : xfer
endmodule : tdbg_master

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic wr_ready = 1'b0;
   logic break_req = 1'b0;
   logic external_bus_request = 1'b1;
   logic scl, m_out, m_oe, s_out, s_oe, pd;
   logic rd_strobe, wr_valid, wr_space, core_halt, bus_grant;
   logic [6:0] rd_addr, wr_addr;
   logic [7:0] rd_data, wr_data, q;
   logic [7:0] n_strobe = 8'h00;
   wire sda;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   // pull-up when neither side drives
   assign sda = m_oe ? m_out : (s_oe ? s_out : 1'b1);
   assign rd_data = {1'b0, rd_addr} ^ 8'ha5;
   tdbg_master i_tdbg_master (.scl(scl), .m_out(m_out), .m_oe(m_oe),
      .sda(sda));
   tdbg_slave i_tdbg_slave (.core_clk(core_clk), .sys_rst(sys_rst),
      .debug_serial_clock(scl), .debug_serial_data_in(sda),
      .debug_serial_data_out(s_out), .debug_serial_data_oe(s_oe),
      .instr_power_down(pd), .rd_addr(rd_addr), .rd_strobe(rd_strobe),
      .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_space(wr_space),
      .break_req(break_req), .core_halt(core_halt),
      .external_bus_request(external_bus_request), .bus_grant(bus_grant));
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      n_strobe <= n_strobe + {7'h00, rd_strobe === 1'b1};
      if (cyc == 12000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask : tick
   task automatic cmp8(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp8
   task automatic cmp1(input string what, input logic exp, input logic got);
      cmp8(what, {7'h00, exp}, {7'h00, got});
   endtask : cmp1
   task automatic wait_grant(input logic v);
      for (int n = 0; n < 20 && bus_grant !== v; n++) begin
         tick();
      end
      cmp1("bus_grant", v, bus_grant);
   endtask : wait_grant
   task automatic t_ignore();
      cmp1("instr_power_down", 1'b1, pd);
      i_tdbg_master.xfer(8'h44, 1'b0, 1'b0, 1'b0, q);
      i_tdbg_master.xfer(8'h12, 1'b0, 1'b1, 1'b0, q);
      tick();
      cmp1("wr_valid", 1'b0, wr_valid);
      cmp8("strobes", 8'h00, n_strobe);
      $display("test ignore done");
   endtask : t_ignore
   task automatic t_fill();
      i_tdbg_master.start();
      i_tdbg_master.xfer({7'h22, 1'b0}, 1'b0, 1'b0, 1'b0, q);
      for (int i = 0; i < 17; i++) begin
         i_tdbg_master.xfer(8'(i), 1'b0, i == 16, i == 0, q);
      end
      tick();
      cmp1("wr_space", 1'b0, wr_space); // buffer full, byte dropped
      for (int i = 0; i < 16; i++) begin
         cmp1("wr_valid", 1'b1, wr_valid);
         cmp8("wr_addr", (i < 14) ? 8'(8'h22 + i) : 8'h30,
            {1'b0, wr_addr});
         cmp8("wr_data", 8'(i), wr_data);
         @(posedge core_clk);
         wr_ready <= 1'b1;
         @(posedge core_clk);
         wr_ready <= 1'b0;
         tick();
      end
      cmp1("wr_valid", 1'b0, wr_valid);
      cmp1("bus_grant", 1'b0, bus_grant);
      $display("test fill done");
   endtask : t_fill
   task automatic t_read();
      logic [6:0] a;
      i_tdbg_master.start();
      i_tdbg_master.xfer({7'h1f, 1'b1}, 1'b0, 1'b0, 1'b0, q);
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 7'h1f : 7'h20;
         i_tdbg_master.xfer(8'hff, 1'b1, i == 2, 1'b0, q);
         cmp8("read byte", {1'b0, a} ^ 8'ha5, q);
      end
      repeat (4) tick();
      cmp8("strobes", 8'h04, n_strobe);
      $display("test read done");
   endtask : t_read
   task automatic t_grant();
      i_tdbg_master.start();
      i_tdbg_master.xfer({7'h17, 1'b0}, 1'b0, 1'b0, 1'b0, q);
      i_tdbg_master.xfer(8'h80, 1'b0, 1'b1, 1'b0, q);
      wait_grant(1'b1);
      i_tdbg_master.start();
      i_tdbg_master.xfer({7'h10, 1'b0}, 1'b0, 1'b0, 1'b0, q);
      wait_grant(1'b0);
      i_tdbg_master.xfer(8'h3c, 1'b0, 1'b0, 1'b0, q);
      wait_grant(1'b0);
      i_tdbg_master.xfer(8'hc3, 1'b0, 1'b1, 1'b0, q);
      wait_grant(1'b1);
      i_tdbg_master.start();
      i_tdbg_master.xfer({7'h17, 1'b1}, 1'b0, 1'b1, 1'b0, q);
      i_tdbg_master.xfer(8'hff, 1'b1, 1'b1, 1'b0, q);
      cmp8("grant status", 8'h01, q);
      @(posedge core_clk);
      break_req <= 1'b1;
      tick();
      cmp1("core_halt", 1'b1, core_halt);
      $display("test grant done");
   endtask : t_grant
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (3) tick();
      t_ignore();
      t_fill();
      t_read();
      t_grant();
      print_verdict();
   end
endmodule : tb_top
